/* hdl/crs_pkg.sv */
/*
 * shared constants and types for both ends of the centered read strobe link.
 * assumes one core clock at 250 MHz on each end and a bus clock made by the host.
 */
package crs_pkg;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int CORE_CLK_NS = 4;
	localparam int BUS_CLK_NS = 32;
	localparam int HALF_CYCLES = BUS_CLK_NS / (2 * CORE_CLK_NS);

	// --------------------------------------------------------------
	// transaction shape
	// --------------------------------------------------------------
	localparam int LAT_CLKS_DEF = 4;
	localparam bit STACKED_DEF = 1'b1;
	localparam int MEM_BYTES_DEF = 64;
	localparam int ADDR_W = 16;
	localparam int CA_W = 48;
	localparam int CA_RD_BIT = 47;
	localparam logic [7:0] CA_EDGES = 8'h06;
	localparam logic [7:0] DBL_SAMPLE_EDGE = 8'h02;
	localparam logic [7:0] BURST_BYTES = 8'h02;
	localparam logic [7:0] CNT_RESET = 8'h00;

	// --------------------------------------------------------------
	// pin sample seen by the device end
	// --------------------------------------------------------------
	typedef struct packed {
		logic sel_n;
		logic ck_p;
		logic ck_n;
		logic sc_p;
		logic sc_n;
		logic rst_n;
		logic strobe;
		logic [7:0] dq;
	} crs_pins_s;

endpackage : crs_pkg

/* hdl/crs_link_if.sv */
/*
 * the link wires between host end and device end, with pin resolution.
 * assumes the testbench instantiates it once and binds both ends to it.
 */
`timescale 1ns/100ps
interface crs_link_if;
	logic select_n;
	logic bus_clk_p;
	logic bus_clk_n;
	logic shifted_clk_p;
	logic shifted_clk_n;
	logic hw_reset_n_o;
	logic hw_reset_n_oe;
	logic hw_reset_n;
	logic strobe_dev_o;
	logic strobe_dev_oe;
	logic strobe_host_o;
	logic strobe_host_oe;
	logic strobe_mask;
	logic [7:0] data_dev_o;
	logic data_dev_oe;
	logic [7:0] data_host_o;
	logic data_host_oe;
	logic [7:0] data_lines;

	// --------------------------------------------------------------
	// wire resolution
	// --------------------------------------------------------------
	// weak pull-up
	assign hw_reset_n = hw_reset_n_oe ? hw_reset_n_o : 1'b1;
	assign strobe_mask = strobe_dev_oe ? strobe_dev_o : (strobe_host_oe & strobe_host_o);
	assign data_lines = data_dev_oe ? data_dev_o : (data_host_oe ? data_host_o : 8'h00);

	modport dev (
		input select_n,
		input bus_clk_p,
		input bus_clk_n,
		input shifted_clk_p,
		input shifted_clk_n,
		input hw_reset_n,
		input strobe_mask,
		input data_lines,
		output strobe_dev_o,
		output strobe_dev_oe,
		output data_dev_o,
		output data_dev_oe
	);

	modport host (
		output select_n,
		output bus_clk_p,
		output bus_clk_n,
		output shifted_clk_p,
		output shifted_clk_n,
		output hw_reset_n_o,
		output hw_reset_n_oe,
		output strobe_host_o,
		output strobe_host_oe,
		output data_host_o,
		output data_host_oe,
		input strobe_mask,
		input data_lines
	);
endinterface : crs_link_if

/* hdl/crs_dev_end.sv */
/*
 * memory-side end of the link: command capture, latency, read with
 * strobe from the shifted clock, masked write into a small byte array.
 * assumes link pins arrive unsynchronised and core_clk is far faster than the bus clock.
 */
`timescale 1ns/100ps
module crs_dev_end #(
	parameter int LAT_CLKS = crs_pkg::LAT_CLKS_DEF,
	parameter bit STACKED = crs_pkg::STACKED_DEF,
	parameter int MEM_BYTES = crs_pkg::MEM_BYTES_DEF
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// link pins
	crs_link_if.dev link,
	// configuration
	input wire logic cfg_diff_mode,
	input wire logic cfg_extra_lat,
	// status
	output logic busy,
	output logic last_cmd_read,
	output logic byte_written,
	output logic [7:0] last_byte
);

	// --------------------------------------------------------------
	// types and constants
	// --------------------------------------------------------------
	localparam int AW = $clog2(MEM_BYTES);
	localparam logic [7:0] LAT_SINGLE = 8'(2 * LAT_CLKS);
	localparam logic [7:0] LAT_DOUBLE = 8'(4 * LAT_CLKS);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CA,
		ST_LAT,
		ST_RD,
		ST_WR
	} crs_dev_st_e;

	typedef struct packed {
		crs_pkg::crs_pins_s s1;
		crs_pkg::crs_pins_s s2;
		logic ck_prev;
		logic sc_prev;
		logic sel_prev;
		crs_dev_st_e st;
		logic [7:0] cnt;
		logic [39:0] ca_hi;
		logic dbl;
		logic [AW-1:0] addr;
		logic [7:0] dq_o;
		logic dq_oe;
		logic strobe_o;
		logic strobe_oe;
		logic busy;
		logic last_rd;
		logic wr_pulse;
		logic [7:0] last_byte;
		logic [MEM_BYTES-1:0][7:0] mem;
	} crs_dev_state_s;

	crs_dev_state_s state_reg;
	crs_dev_state_s state_next;
	crs_pkg::crs_pins_s pins_now;
	logic ck_lvl;
	logic sc_lvl;
	logic ck_edge;
	logic sc_edge;
	logic sel_fall;
	logic [7:0] lat_edges;
	logic [47:0] ca_full;

	// --------------------------------------------------------------
	// pin gathering
	// --------------------------------------------------------------
	always_comb begin
		pins_now.sel_n = link.select_n;
		pins_now.ck_p = link.bus_clk_p;
		pins_now.ck_n = link.bus_clk_n;
		pins_now.sc_p = link.shifted_clk_p;
		pins_now.sc_n = link.shifted_clk_n;
		pins_now.rst_n = link.hw_reset_n;
		pins_now.strobe = link.strobe_mask;
		pins_now.dq = link.data_lines;
	end

	// --------------------------------------------------------------
	// clock levels and edges
	// --------------------------------------------------------------
	always_comb begin
		ck_lvl = cfg_diff_mode ? (state_reg.s2.ck_p & ~state_reg.s2.ck_n) : state_reg.s2.ck_p;
		sc_lvl = cfg_diff_mode ? (state_reg.s2.sc_p & ~state_reg.s2.sc_n) : state_reg.s2.sc_p;
		ck_edge = ck_lvl ^ state_reg.ck_prev;
		sc_edge = sc_lvl ^ state_reg.sc_prev;
		sel_fall = state_reg.sel_prev & ~state_reg.s2.sel_n;
		lat_edges = state_reg.dbl ? LAT_DOUBLE : LAT_SINGLE;
		ca_full = {state_reg.ca_hi, state_reg.s2.dq};
	end

	// --------------------------------------------------------------
	// transaction engine
	// --------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.s1 = pins_now;
		state_next.s2 = state_reg.s1;
		state_next.ck_prev = ck_lvl;
		state_next.sc_prev = sc_lvl;
		state_next.sel_prev = state_reg.s2.sel_n;
		state_next.wr_pulse = 1'b0;
		if (!state_reg.s2.rst_n) begin
			state_next.st = ST_IDLE;
			state_next.cnt = crs_pkg::CNT_RESET;
			state_next.busy = 1'b0;
			state_next.dq_oe = 1'b0;
			state_next.strobe_oe = 1'b0;
		end else if (state_reg.s2.sel_n) begin
			state_next.st = ST_IDLE;
			state_next.busy = 1'b0;
			state_next.dq_oe = 1'b0;
			state_next.strobe_oe = 1'b0;
		end else begin
			case (state_reg.st)
				ST_IDLE: begin
					if (sel_fall) begin
						state_next.st = ST_CA;
						state_next.cnt = crs_pkg::CNT_RESET;
						state_next.busy = 1'b1;
						state_next.dbl = STACKED | cfg_extra_lat;
						state_next.strobe_oe = 1'b1;
						state_next.strobe_o = STACKED | cfg_extra_lat;
					end
				end
				ST_CA: begin
					if (ck_edge) begin
						state_next.ca_hi = ca_full[39:0];
						state_next.cnt = state_reg.cnt + 8'h01;
						if (state_reg.cnt == crs_pkg::CA_EDGES - 8'h01) begin
							state_next.st = ST_LAT;
							state_next.cnt = crs_pkg::CNT_RESET;
							state_next.strobe_oe = 1'b0;
							state_next.last_rd = ca_full[crs_pkg::CA_RD_BIT];
							state_next.addr = ca_full[AW-1:0];
						end
					end
				end
				ST_LAT: begin
					if (ck_edge) begin
						state_next.cnt = state_reg.cnt + 8'h01;
						if (state_reg.cnt == lat_edges - 8'h01) begin
							state_next.cnt = crs_pkg::CNT_RESET;
							if (state_reg.last_rd) begin
								state_next.st = ST_RD;
								state_next.strobe_oe = 1'b1;
								state_next.strobe_o = 1'b0;
							end else begin
								state_next.st = ST_WR;
							end
						end
					end
				end
				ST_RD: begin
					if (ck_edge) begin
						state_next.dq_o = state_reg.mem[state_reg.addr];
						state_next.dq_oe = 1'b1;
						state_next.addr = state_reg.addr + 1'b1;
					end
					if (sc_edge) begin
						state_next.strobe_o = ~state_reg.strobe_o;
					end
				end
				ST_WR: begin
					if (ck_edge) begin
						state_next.addr = state_reg.addr + 1'b1;
						if (!state_reg.s2.strobe) begin
							state_next.mem[state_reg.addr] = state_reg.s2.dq;
							state_next.wr_pulse = 1'b1;
							state_next.last_byte = state_reg.s2.dq;
						end
					end
				end
				default: begin
					state_next.st = ST_IDLE;
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// state register
	// --------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
			state_reg.s1.sel_n <= 1'b1;
			state_reg.s2.sel_n <= 1'b1;
			state_reg.sel_prev <= 1'b1;
			state_reg.s1.rst_n <= 1'b1;
			state_reg.s2.rst_n <= 1'b1;
			state_reg.st <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign link.data_dev_o = state_reg.dq_o;
	assign link.data_dev_oe = state_reg.dq_oe;
	assign link.strobe_dev_o = state_reg.strobe_o;
	assign link.strobe_dev_oe = state_reg.strobe_oe;
	assign busy = state_reg.busy;
	assign last_cmd_read = state_reg.last_rd;
	assign byte_written = state_reg.wr_pulse;
	assign last_byte = state_reg.last_byte;

endmodule : crs_dev_end

/* hdl/crs_host_end.sv */
/*
 * controller end of the link: makes bus and shifted clocks by division,
 * sends a two-byte read or write, collects read bytes on strobe edges.
 * assumes the device end answers with the same latency setting.
 */
`timescale 1ns/100ps
module crs_host_end #(
	parameter int LAT_CLKS = crs_pkg::LAT_CLKS_DEF,
	parameter int HALF = crs_pkg::HALF_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// link pins
	crs_link_if.host link,
	// request port
	input wire logic req_valid,
	input wire logic req_read,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_wdata,
	input wire logic [1:0] req_mask,
	output logic req_ready,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	// configuration
	input wire logic cfg_diff_mode,
	input wire logic hw_reset_req
);

	// --------------------------------------------------------------
	// types and constants
	// --------------------------------------------------------------
	localparam logic [7:0] HALF_LAST = 8'(HALF - 1);
	localparam logic [7:0] MID = 8'(HALF / 2 - 1);
	localparam logic [7:0] LAT_SINGLE = 8'(2 * LAT_CLKS);
	localparam logic [7:0] LAT_DOUBLE = 8'(4 * LAT_CLKS);

	typedef enum logic [1:0] {
		H_IDLE,
		H_SEL,
		H_RUN,
		H_END
	} crs_host_st_e;

	typedef struct packed {
		logic [8:0] s1;
		logic [8:0] s2;
		logic strobe_prev;
		crs_host_st_e st;
		logic [7:0] cnt;
		logic [7:0] e;
		logic is_rd;
		logic dbl;
		logic [47:0] ca;
		logic [15:0] wdata;
		logic [1:0] mask;
		logic ck;
		logic ck_n;
		logic sc;
		logic sc_n;
		logic sel_n;
		logic [7:0] dq_o;
		logic dq_oe;
		logic strobe_o;
		logic strobe_oe;
		logic [1:0] rx;
		logic [15:0] rdata;
		logic rsp_valid;
		logic ready;
		logic rst_n_o;
		logic rst_oe;
	} crs_host_state_s;

	crs_host_state_s state_reg;
	crs_host_state_s state_next;
	logic [7:0] data_e;
	logic [7:0] last_e;

	// --------------------------------------------------------------
	// controller
	// --------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.s1 = {link.strobe_mask, link.data_lines};
		state_next.s2 = state_reg.s1;
		state_next.strobe_prev = state_reg.s2[8];
		state_next.rsp_valid = 1'b0;
		state_next.rst_n_o = ~hw_reset_req;
		state_next.rst_oe = hw_reset_req;
		data_e = crs_pkg::CA_EDGES + (state_reg.dbl ? LAT_DOUBLE : LAT_SINGLE);
		last_e = data_e + crs_pkg::BURST_BYTES;
		case (state_reg.st)
			H_IDLE: begin
				state_next.ready = 1'b1;
				if (req_valid && state_reg.ready) begin
					state_next.ready = 1'b0;
					state_next.st = H_SEL;
					state_next.cnt = crs_pkg::CNT_RESET;
					state_next.e = crs_pkg::CNT_RESET;
					state_next.is_rd = req_read;
					state_next.dbl = 1'b0;
					state_next.ca = {req_read, 31'h00000000, req_addr};
					state_next.wdata = req_wdata;
					state_next.mask = req_mask;
					state_next.rx = 2'h0;
					state_next.ck = 1'b0;
					state_next.sel_n = 1'b0;
					state_next.dq_o = {req_read, 7'h00};
					state_next.dq_oe = 1'b1;
				end
			end
			H_SEL: begin
				state_next.cnt = state_reg.cnt + 8'h01;
				if (state_reg.cnt == HALF_LAST) begin
					state_next.st = H_RUN;
					state_next.cnt = crs_pkg::CNT_RESET;
				end
			end
			H_RUN: begin
				state_next.cnt = (state_reg.cnt == HALF_LAST) ? crs_pkg::CNT_RESET : state_reg.cnt + 8'h01;
				if (state_reg.cnt == MID) begin
					if (state_reg.e < crs_pkg::CA_EDGES) begin
						state_next.dq_o = state_reg.ca[47:40];
					end else if (state_reg.is_rd) begin
						state_next.dq_oe = 1'b0;
						if (state_reg.e > data_e && state_reg.e <= last_e) begin
							state_next.sc = ~state_reg.sc;
						end
					end else if (state_reg.e >= data_e && state_reg.e < last_e) begin
						state_next.dq_o = (state_reg.e == data_e) ? state_reg.wdata[15:8] : state_reg.wdata[7:0];
						state_next.strobe_oe = 1'b1;
						state_next.strobe_o = (state_reg.e == data_e) ? state_reg.mask[1] : state_reg.mask[0];
					end
				end
				if (state_reg.cnt == HALF_LAST && state_reg.e < last_e) begin
					state_next.ck = ~state_reg.ck;
					state_next.e = state_reg.e + 8'h01;
					state_next.ca = {state_reg.ca[39:0], 8'h00};
					if (state_reg.e == crs_pkg::DBL_SAMPLE_EDGE) begin
						state_next.dbl = state_reg.s2[8];
					end
				end
				if (!state_reg.is_rd && state_reg.cnt == HALF_LAST && state_reg.e == last_e) begin
					state_next.st = H_END;
					state_next.cnt = crs_pkg::CNT_RESET;
				end
				if (state_reg.is_rd && state_reg.e > data_e && state_reg.s2[8] != state_reg.strobe_prev) begin
					state_next.rdata = {state_reg.rdata[7:0], state_reg.s2[7:0]};
					state_next.rx = state_reg.rx + 2'h1;
					if (state_reg.rx == 2'h1) begin
						state_next.rsp_valid = 1'b1;
						state_next.st = H_END;
						state_next.cnt = crs_pkg::CNT_RESET;
					end
				end
			end
			H_END: begin
				state_next.sel_n = 1'b1;
				state_next.ck = 1'b0;
				state_next.sc = 1'b0;
				state_next.dq_oe = 1'b0;
				state_next.strobe_oe = 1'b0;
				state_next.cnt = state_reg.cnt + 8'h01;
				if (state_reg.cnt == HALF_LAST) begin
					state_next.st = H_IDLE;
					state_next.ready = 1'b1;
				end
			end
			default: begin
				state_next.st = H_IDLE;
			end
		endcase
		// complementary negatives for both clock pairs, negative low if single
		state_next.ck_n = cfg_diff_mode & ~state_next.ck;
		state_next.sc_n = cfg_diff_mode & ~state_next.sc;
	end

	// --------------------------------------------------------------
	// state register
	// --------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
			state_reg.st <= H_IDLE;
			state_reg.sel_n <= 1'b1;
			state_reg.rst_n_o <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign link.select_n = state_reg.sel_n;
	assign link.bus_clk_p = state_reg.ck;
	assign link.bus_clk_n = state_reg.ck_n;
	assign link.shifted_clk_p = state_reg.sc;
	assign link.shifted_clk_n = state_reg.sc_n;
	assign link.hw_reset_n_o = state_reg.rst_n_o;
	assign link.hw_reset_n_oe = state_reg.rst_oe;
	assign link.data_host_o = state_reg.dq_o;
	assign link.data_host_oe = state_reg.dq_oe;
	assign link.strobe_host_o = state_reg.strobe_o;
	assign link.strobe_host_oe = state_reg.strobe_oe;
	assign req_ready = state_reg.ready;
	assign rsp_valid = state_reg.rsp_valid;
	assign rsp_data = state_reg.rdata;

endmodule : crs_host_end

/* test/crs_link_chk.sv */
/*
 * assertions on the link wires between the host end and the device end.
 * assumes the testbench instantiates it once beside the link interface.
 */
`timescale 1ns/100ps
module crs_link_chk (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// host driven wires
	input wire logic select_n,
	input wire logic bus_clk_p,
	input wire logic shifted_clk_p,
	input wire logic hw_reset_n_oe,
	input wire logic hw_reset_n,
	input wire logic strobe_host_o,
	input wire logic strobe_host_oe,
	input wire logic data_host_oe,
	// device driven wires
	input wire logic strobe_dev_o,
	input wire logic strobe_dev_oe,
	input wire logic [7:0] data_dev_o,
	input wire logic data_dev_oe
);
	logic [3:0] ck_age_reg;
	logic [3:0] sc_age_reg;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	// ----------------------------------------------------------
	// cycles since last clock edges
	// ----------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ck_age_reg <= 4'hF;
			sc_age_reg <= 4'hF;
		end else begin
			ck_age_reg <= $changed(bus_clk_p) ? 4'h0 : ck_age_reg + {3'h0, ck_age_reg != 4'hF};
			sc_age_reg <= $changed(shifted_clk_p) ? 4'h0 : sc_age_reg + {3'h0, sc_age_reg != 4'hF};
		end
	end

	// ----------------------------------------------------------
	// assertions
	// ----------------------------------------------------------
	chk_reset_pull_up: assert property (!hw_reset_n_oe |-> hw_reset_n)
		else $error("reset wire low while undriven");
	chk_reset_release_pins: assert property (!hw_reset_n [*5] |-> !strobe_dev_oe && !data_dev_oe)
		else $error("device drives pins during hardware reset");
	chk_end_releases_pins: assert property ($rose(select_n) |-> ##[0:8] (!strobe_dev_oe && !data_dev_oe))
		else $error("device pins not released after frame end");
	chk_start_latency_flag: assert property ($fell(select_n) && hw_reset_n |-> ##[1:8] strobe_dev_oe)
		else $error("no latency flag at frame start");
	chk_flag_doubled: assert property (strobe_dev_oe && data_host_oe |-> strobe_dev_o)
		else $error("latency flag low on stacked device");
	chk_data_one_driver: assert property (data_dev_oe |-> !data_host_oe && !strobe_host_oe)
		else $error("device drives data while host drives");
	chk_mask_is_input: assert property (strobe_host_oe |-> !strobe_dev_oe)
		else $error("device drives strobe during write mask");
	chk_strobe_from_shift: assert property ($changed(strobe_dev_o) && data_dev_oe && $past(data_dev_oe)
		|-> sc_age_reg <= 4'h6)
		else $error("read strobe moved without shifted clock edge");
	chk_data_from_bus_clk: assert property ($changed(data_dev_o) && data_dev_oe && $past(data_dev_oe)
		|-> ck_age_reg <= 4'h6)
		else $error("read data moved without bus clock edge");
	chk_shift_still_write: assert property (strobe_host_oe |-> $stable(shifted_clk_p))
		else $error("shifted clock moves during write");
	chk_start_clock_low: assert property ($fell(select_n) |-> !bus_clk_p)
		else $error("frame started with bus clock high");

	// ----------------------------------------------------------
	// covers
	// ----------------------------------------------------------
	cov_read_data: cover property (data_dev_oe && $changed(strobe_dev_o));
	cov_masked_write: cover property (strobe_host_oe && strobe_host_o);
	cov_hw_reset: cover property (!hw_reset_n [*5]);
endmodule : crs_link_chk

/* test/testbench.sv */
/*
 * self-checking bench: host end and device end joined by one link.
 * assumes both ends use the package defaults for latency and timing.
 */
`timescale 1ns/100ps
module testbench;
	logic core_clk;
	logic resetn;
	logic cfg_diff_mode;
	logic cfg_extra_lat;
	logic hw_reset_req;
	logic req_valid;
	logic req_read;
	logic [15:0] req_addr;
	logic [15:0] req_wdata;
	logic [1:0] req_mask;
	logic req_ready;
	logic rsp_valid;
	logic [15:0] rsp_data;
	logic busy;
	logic last_cmd_read;
	logic byte_written;
	logic [7:0] last_byte;
	logic [15:0] rd_data;
	int failures;
	int samples_checked;
	int wr_count;
	int cycle_count;

	crs_link_if u_crs_link_if ();

	crs_dev_end u_crs_dev_end (.core_clk(core_clk), .resetn(resetn), .link(u_crs_link_if.dev),
		.cfg_diff_mode(cfg_diff_mode), .cfg_extra_lat(cfg_extra_lat), .busy(busy),
		.last_cmd_read(last_cmd_read), .byte_written(byte_written), .last_byte(last_byte));

	crs_host_end u_crs_host_end (.core_clk(core_clk), .resetn(resetn), .link(u_crs_link_if.host),
		.req_valid(req_valid), .req_read(req_read), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_mask(req_mask), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.cfg_diff_mode(cfg_diff_mode), .hw_reset_req(hw_reset_req));

	crs_link_chk u_crs_link_chk (.core_clk(core_clk), .resetn(resetn),
		.select_n(u_crs_link_if.select_n), .bus_clk_p(u_crs_link_if.bus_clk_p),
		.shifted_clk_p(u_crs_link_if.shifted_clk_p), .hw_reset_n_oe(u_crs_link_if.hw_reset_n_oe),
		.hw_reset_n(u_crs_link_if.hw_reset_n), .strobe_host_o(u_crs_link_if.strobe_host_o),
		.strobe_host_oe(u_crs_link_if.strobe_host_oe), .data_host_oe(u_crs_link_if.data_host_oe),
		.strobe_dev_o(u_crs_link_if.strobe_dev_o), .strobe_dev_oe(u_crs_link_if.strobe_dev_oe),
		.data_dev_o(u_crs_link_if.data_dev_o), .data_dev_oe(u_crs_link_if.data_dev_oe));

	// ----------------------------------------------------------
	// clock, watchdog and monitors
	// ----------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycle_count <= cycle_count + 1;
		if (byte_written === 1'b1) begin
			wr_count <= wr_count + 1;
		end
		if (cycle_count == 8000) begin
			failures = failures + 1;
			finish_test();
		end
		if (resetn === 1'b1 && cfg_diff_mode === 1'b0 && u_crs_link_if.select_n === 1'b0) begin
			check("negative clocks", {14'h0, u_crs_link_if.bus_clk_n, u_crs_link_if.shifted_clk_n}, 16'h0000);
		end
	end

	// ----------------------------------------------------------
	// tasks
	// ----------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic xfer(input logic rd, input logic [15:0] addr, input logic [15:0] wdata,
		input logic [1:0] mask);
		@(posedge core_clk);
		req_valid <= 1'b1;
		req_read <= rd;
		req_addr <= addr;
		req_wdata <= wdata;
		req_mask <= mask;
		do @(posedge core_clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		if (rd) begin
			do @(posedge core_clk); while (rsp_valid !== 1'b1);
			rd_data = rsp_data;
		end
		do @(posedge core_clk); while (req_ready !== 1'b1);
		repeat (4) @(posedge core_clk);
	endtask : xfer

	task automatic write_word(input logic [15:0] addr, input logic [15:0] wdata, input logic [1:0] mask,
		input int bytes);
		xfer(1'b0, addr, wdata, mask);
		check("bytes stored", 16'(wr_count), 16'(bytes));
		check("busy after write", {15'h0, busy}, 16'h0000);
		check("read flag after write", {15'h0, last_cmd_read}, 16'h0000);
	endtask : write_word

	task automatic read_word(input logic [15:0] addr, input logic [15:0] exp);
		xfer(1'b1, addr, 16'h0000, 2'b00);
		check("read data", rd_data, exp);
		check("read flag after read", {15'h0, last_cmd_read}, 16'h0001);
	endtask : read_word

	task automatic finish_test();
		if (failures == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial begin
		resetn = 1'b0;
		cfg_diff_mode = 1'b1;
		cfg_extra_lat = 1'b0;
		hw_reset_req = 1'b0;
		req_valid = 1'b0;
		req_read = 1'b0;
		req_addr = 16'h0000;
		req_wdata = 16'h0000;
		req_mask = 2'b00;
		failures = 0;
		samples_checked = 0;
		wr_count = 0;
		cycle_count = 0;
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge core_clk);
		write_word(16'h0010, 16'hA55A, 2'b00, 2);
		check("last byte", {8'h00, last_byte}, 16'h005A);
		read_word(16'h0010, 16'hA55A);
		// first byte masked then second byte masked
		write_word(16'h0010, 16'h1234, 2'b10, 3);
		check("last byte", {8'h00, last_byte}, 16'h0034);
		write_word(16'h0010, 16'h5678, 2'b01, 4);
		read_word(16'h0010, 16'h5634);
		// extra latency request changes nothing on stacked part
		cfg_extra_lat <= 1'b1;
		write_word(16'h003E, 16'hC33C, 2'b00, 6);
		read_word(16'h003E, 16'hC33C);
		cfg_diff_mode <= 1'b0;
		write_word(16'h0020, 16'h0FF0, 2'b00, 8);
		read_word(16'h0020, 16'h0FF0);
		read_word(16'h0010, 16'h5634);
		cfg_diff_mode <= 1'b1;
		// hardware reset in mid-frame releases pins, idles device
		fork
			xfer(1'b0, 16'h0020, 16'hFFFF, 2'b00);
			begin
				repeat (7) @(posedge core_clk);
				check("busy in frame", {15'h0, busy}, 16'h0001);
				check("latency flag driven", {15'h0, u_crs_link_if.strobe_dev_oe}, 16'h0001);
				hw_reset_req <= 1'b1;
				repeat (8) @(posedge core_clk);
				check("reset wire", {15'h0, u_crs_link_if.hw_reset_n}, 16'h0000);
				check("dev pin enables", {14'h0, u_crs_link_if.strobe_dev_oe, u_crs_link_if.data_dev_oe}, 16'h0000);
				check("busy in reset", {15'h0, busy}, 16'h0000);
				hw_reset_req <= 1'b0;
			end
		join
		check("bytes after reset", 16'(wr_count), 16'h0008);
		read_word(16'h0020, 16'h0FF0);
		read_word(16'h003E, 16'hC33C);
		finish_test();
	end
endmodule : testbench
